// [cbu_pkg.sv]
// Shared constants and types for the clock breakpoint unit
package cbu_pkg;

    // Register bus widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_DELAY    = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_CMD      = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h14;

    // CTRL fields
    localparam int CTRL_ALL_BIT = 0;
    localparam int CTRL_SEL_LSB = 4;
    localparam int SEL_W        = 4;

    // DELAY field
    localparam int DELAY_W = 8;

    // CMD bits, write one to issue
    localparam int CMD_ARM_BIT   = 0;
    localparam int CMD_HALT_BIT  = 1;
    localparam int CMD_PLAY_BIT  = 2;
    localparam int CMD_STEP_BIT  = 3;
    localparam int CMD_RESET_BIT = 4;

    // STATUS fields
    localparam int STAT_ARMED_BIT  = 0;
    localparam int STAT_HALTED_BIT = 1;
    localparam int STAT_DELAY_BIT  = 2;
    localparam int STAT_EN_BIT     = 3;
    localparam int STAT_CNT_LSB    = 8;

    // Interrupt bits
    localparam int IRQ_W        = 2;
    localparam int IRQ_HALT_BIT = 0;
    localparam int IRQ_FIRE_BIT = 1;

    // Reset values
    localparam logic [DELAY_W-1:0] DELAY_RST    = 8'h00;
    localparam logic [SEL_W-1:0]   SEL_RST      = 4'h0;
    localparam logic [IRQ_W-1:0]   IRQ_MASK_RST = 2'h0;

    // Cycles between neighbouring domains in all-domain sequencing
    localparam logic [7:0] SEQ_GAP = 8'h04;

    // Halt latency bound in domain cycles
    localparam int HALT_LAT_CYC = 1;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } cbu_bus_req_t;

    typedef struct packed {
        logic halt;
        logic play;
        logic step;
    } cbu_seq_cmd_t;

    typedef enum logic [2:0] {
        ST_RUN,
        ST_ARMED,
        ST_DELAY,
        ST_HALTED,
        ST_STEP
    } cbu_state_t;

endpackage

// [cbu_unit.sv]
// Clock breakpoint unit: gates one user clock domain for debug
//
// Contract
// - One unit per gated domain; each unit gates its own domain clock.
// - Mode write switches the unit between single-domain and all-domain.
// - Armed unit halts on next rising edge of the trigger probe.
// - Halt delay 0..255 loaded before arming; halt that many cycles after trigger.
// - Forced halt ignores the programmed delay; it waits only for its all-domain sequencing slot.
// - While armed, only forced halt and reset are accepted.
// - Forced halt stops selected or every domain without waiting for trigger.
// - All-domain forced halt reaches domains in fixed domain order.
// - Play on halted domain restarts its clock from halted state.
// - All-domain play and step reach domains in same fixed order.
// - Step on halted domain releases exactly one cycle, then stays halted.
// - All-domain halt, play, step act on every domain, not one.
// - Changing selected domain drops previous domain's breakpoint settings.
// - Reset at any time returns unit to idle and stops trigger watch.
// - Domains not halted keep running while others are halted.
// - Halt lands within one domain cycle of the halt condition.
`timescale 1ns/1ps

module cbu_unit
    import cbu_pkg::*;
#(
    parameter logic [SEL_W-1:0] DOMAIN_ID = 4'h0
) (
    // Clock and reset of the domain source
    input  wire logic              clk,
    input  wire logic              rst,
    // Register port
    input  wire cbu_bus_req_t      bus_req,
    output      logic [DATA_W-1:0] rdata_q,
    // Trigger probe, synchronous to clk
    input  wire logic              probe_trig,
    // Gated domain clock and status
    output      logic              gclk,
    output      logic              halted_q,
    output      logic              irq_q
);

    // True when a command reaches this domain
    function automatic logic targets(input logic all_mode, input logic [SEL_W-1:0] sel);
        targets = all_mode || (sel == DOMAIN_ID);
    endfunction

    // Sequencing wait for this domain in all-domain mode
    function automatic logic [7:0] stagger(input logic all_mode);
        logic [7:0] id8;
        id8 = {{(8-SEL_W){1'b0}}, DOMAIN_ID};
        stagger = all_mode ? 8'(id8 * SEQ_GAP) : 8'h00;
    endfunction

    logic               all_q;
    logic [SEL_W-1:0]   sel_q;
    logic [DELAY_W-1:0] delay_q;
    logic [DELAY_W-1:0] cnt_q;
    logic [DELAY_W-1:0] cnt_d;
    cbu_state_t         state_q;
    cbu_state_t         state_d;
    cbu_seq_cmd_t       pend_q;
    logic [7:0]         wait_q;
    logic               trig_q;
    logic               en_q;
    logic               en_neg_q;
    logic [IRQ_W-1:0]   irq_stat_q;
    logic [IRQ_W-1:0]   irq_mask_q;

    logic               wr_ctrl;
    logic               wr_delay;
    logic               wr_cmd;
    logic               sel_change;
    logic               hit;
    logic               armed;
    logic               cmd_arm;
    logic               cmd_halt;
    logic               cmd_play;
    logic               cmd_step;
    logic               cmd_reset;
    logic               go;
    logic               trig_rise;
    logic [IRQ_W-1:0]   irq_ev;
    logic [IRQ_W-1:0]   irq_stat_d;

    // Decode of the register port
    assign wr_ctrl    = bus_req.wr && (bus_req.addr == OFS_CTRL);
    assign wr_delay   = bus_req.wr && (bus_req.addr == OFS_DELAY);
    assign wr_cmd     = bus_req.wr && (bus_req.addr == OFS_CMD);
    assign sel_change = wr_ctrl && (bus_req.wdata[CTRL_SEL_LSB +: SEL_W] != sel_q);
    assign hit        = targets(all_q, sel_q);
    assign armed      = (state_q == ST_ARMED) || (state_q == ST_DELAY);

    // Commands; while armed only halt and reset get through
    assign cmd_reset = wr_cmd && hit && bus_req.wdata[CMD_RESET_BIT];
    assign cmd_halt  = wr_cmd && hit && bus_req.wdata[CMD_HALT_BIT]
                       && !cmd_reset;
    assign cmd_arm   = wr_cmd && hit && bus_req.wdata[CMD_ARM_BIT]
                       && !armed && !cmd_reset && !cmd_halt;
    assign cmd_play  = wr_cmd && hit && bus_req.wdata[CMD_PLAY_BIT]
                       && !armed && !cmd_reset && !cmd_halt;
    assign cmd_step  = wr_cmd && hit && bus_req.wdata[CMD_STEP_BIT]
                       && !armed && !cmd_reset && !cmd_halt && !cmd_play;

    // Rising edge on the probe, positive edge only
    assign trig_rise = probe_trig && !trig_q;

    // Pending sequenced command is due
    assign go = (pend_q != '0) && (wait_q == 8'h00);

    // Mode and domain select
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            all_q <= 1'b0;
            sel_q <= SEL_RST;
        end else if (wr_ctrl) begin
            all_q <= bus_req.wdata[CTRL_ALL_BIT];
            sel_q <= bus_req.wdata[CTRL_SEL_LSB +: SEL_W];
        end
    end

    // Halt delay; locked while armed, dropped on a change of domain
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            delay_q <= DELAY_RST;
        end else if (sel_change || cmd_reset) begin
            delay_q <= DELAY_RST;
        end else if (wr_delay && !armed) begin
            delay_q <= bus_req.wdata[DELAY_W-1:0];
        end
    end

    // Sequenced halt, play and step; lower domain ids act first
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pend_q <= '0;
            wait_q <= 8'h00;
        end else if (cmd_reset || sel_change) begin
            pend_q <= '0;
            wait_q <= 8'h00;
        end else if (cmd_halt || cmd_play || cmd_step) begin
            pend_q.halt <= cmd_halt;
            pend_q.play <= cmd_play;
            pend_q.step <= cmd_step;
            wait_q      <= stagger(all_q);
        end else if (go) begin
            pend_q <= '0;
        end else if (wait_q != 8'h00) begin
            wait_q <= wait_q - 8'h01;
        end
    end

    // Next state of the breakpoint unit
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        if (cmd_reset) begin
            state_d = ST_RUN;
            cnt_d   = '0;
        end else if (go && pend_q.halt && (state_q != ST_HALTED)) begin
            state_d = ST_HALTED;
            cnt_d   = '0;
        end else begin
            case (state_q)
                ST_RUN: begin
                    if (cmd_arm) begin
                        state_d = ST_ARMED;
                    end
                end
                ST_ARMED: begin
                    if (sel_change) begin
                        state_d = ST_RUN;
                    end else if (trig_rise && (delay_q == '0)) begin
                        state_d = ST_HALTED;
                    end else if (trig_rise) begin
                        state_d = ST_DELAY;
                        cnt_d   = delay_q;
                    end
                end
                ST_DELAY: begin
                    if (sel_change) begin
                        state_d = ST_RUN;
                        cnt_d   = '0;
                    end else if (cnt_q <= 8'h01) begin
                        state_d = ST_HALTED;
                        cnt_d   = '0;
                    end else begin
                        cnt_d = cnt_q - 8'h01;
                    end
                end
                ST_HALTED: begin
                    if (go && pend_q.play) begin
                        state_d = ST_RUN;
                    end else if (go && pend_q.step) begin
                        state_d = ST_STEP;
                    end
                end
                ST_STEP: begin
                    state_d = ST_HALTED;
                end
                default: begin
                    state_d = ST_RUN;
                    cnt_d   = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_RUN;
            cnt_q   <= '0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            trig_q <= 1'b0;
        end else begin
            trig_q <= probe_trig;
        end
    end

    // Clock enable follows the next state, so a halt costs one cycle at most
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            en_q     <= 1'b1;
            halted_q <= 1'b0;
        end else begin
            en_q     <= (state_d != ST_HALTED);
            halted_q <= (state_d == ST_HALTED);
        end
    end

    // Enable is retimed while clk is low, so the AND cannot clip a high phase
    always_ff @(negedge clk or posedge rst) begin
        if (rst) begin
            en_neg_q <= 1'b1;
        end else begin
            en_neg_q <= en_q;
        end
    end

    // Only gated output; a flop here would halve the domain clock
    assign gclk = clk & en_neg_q;

    // Interrupt status: halt entry and trigger fire, write one to clear
    assign irq_ev[IRQ_HALT_BIT] = (state_q != ST_HALTED) && (state_d == ST_HALTED);
    assign irq_ev[IRQ_FIRE_BIT] = (state_q == ST_ARMED) && (state_d != ST_ARMED)
                                  && trig_rise;

    always_comb begin
        irq_stat_d = irq_stat_q;
        if (bus_req.wr && (bus_req.addr == OFS_IRQ_STAT)) begin
            irq_stat_d = irq_stat_d & ~bus_req.wdata[IRQ_W-1:0];
        end
        // Set wins over a clear in the same cycle
        irq_stat_d = irq_stat_d | irq_ev;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_stat_q <= '0;
            irq_mask_q <= IRQ_MASK_RST;
            irq_q      <= 1'b0;
        end else begin
            irq_stat_q <= irq_stat_d;
            if (bus_req.wr && (bus_req.addr == OFS_IRQ_MASK)) begin
                irq_mask_q <= bus_req.wdata[IRQ_W-1:0];
            end
            irq_q <= |(irq_stat_d & irq_mask_q);
        end
    end

    // Read data one cycle after the strobe; unmapped reads return zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q <= '0;
        end else if (bus_req.rd) begin
            rdata_q <= '0;
            case (bus_req.addr)
                OFS_CTRL: begin
                    rdata_q[CTRL_ALL_BIT]               <= all_q;
                    rdata_q[CTRL_SEL_LSB +: SEL_W]      <= sel_q;
                end
                OFS_DELAY: begin
                    rdata_q[DELAY_W-1:0] <= delay_q;
                end
                OFS_STATUS: begin
                    rdata_q[STAT_ARMED_BIT]             <= armed;
                    rdata_q[STAT_HALTED_BIT]            <= (state_q == ST_HALTED);
                    rdata_q[STAT_DELAY_BIT]             <= (state_q == ST_DELAY);
                    rdata_q[STAT_EN_BIT]                <= en_q;
                    rdata_q[STAT_CNT_LSB +: DELAY_W]    <= cnt_q;
                end
                OFS_IRQ_STAT: begin
                    rdata_q[IRQ_W-1:0] <= irq_stat_q;
                end
                OFS_IRQ_MASK: begin
                    rdata_q[IRQ_W-1:0] <= irq_mask_q;
                end
                default: begin
                    rdata_q <= '0;
                end
            endcase
        end else begin
            rdata_q <= '0;
        end
    end

endmodule // cbu_unit

// [cbu_host.sv]
// Host debug controller model driving the register port
`timescale 1ns/1ps
module cbu_host
    import cbu_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // Register port
    output      cbu_bus_req_t      bus_req,
    input  wire logic [DATA_W-1:0] rdata
);
    initial bus_req = '0;
    // One-cycle strobe; a gap cycle keeps each strobe edge distinct
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req.rd <= 1'b0;
        // Data stand for one cycle only; take them mid-cycle, clear of both edges
        @(negedge clk);
        d = rdata;
    endtask
    // Delay goes in before arming, nothing else follows while armed
    task automatic arm(input logic [DELAY_W-1:0] n);
        wr(OFS_DELAY, {24'h0, n});
        wr(OFS_CMD, 32'h1 << CMD_ARM_BIT);
    endtask
endmodule // cbu_host

// [cbu_unit_monitor.sv]
// Port checker for the clock breakpoint unit
`timescale 1ns/1ps
module cbu_unit_monitor
    import cbu_pkg::*;
#(
    parameter logic [SEL_W-1:0] DOMAIN_ID = 4'h0
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // Register port
    input  wire cbu_bus_req_t      bus_req,
    input  wire logic [DATA_W-1:0] rdata_q,
    // Probe and domain outputs
    input  wire logic              probe_trig,
    input  wire logic              gclk,
    input  wire logic              halted_q,
    input  wire logic              irq_q
);
    // Commands pass a pending stage, so the state moves two edges after the write
    localparam int SEQ_D = int'(DOMAIN_ID) * int'(SEQ_GAP) + 2;
    logic             all_q;
    logic [SEL_W-1:0] sel_q;
    logic             mask_q;
    logic [8:0]       cause_q;
    logic [8:0]       cmd_age_q;
    wire logic        cmd_w  = bus_req.wr && bus_req.addr == OFS_CMD;
    wire logic        mine   = !all_q && sel_q == DOMAIN_ID;
    wire logic        halt_w = cmd_w && bus_req.wdata[CMD_HALT_BIT]
                               && !bus_req.wdata[CMD_RESET_BIT];
    wire logic        rst_w  = cmd_w && bus_req.wdata[CMD_RESET_BIT];
    // Mode mirror tells whether a command targets this unit
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            all_q  <= 1'b0;
            sel_q  <= SEL_RST;
            mask_q <= 1'b0;
        end else if (bus_req.wr && bus_req.addr == OFS_CTRL) begin
            all_q <= bus_req.wdata[CTRL_ALL_BIT];
            sel_q <= bus_req.wdata[CTRL_SEL_LSB +: SEL_W];
        end else if (bus_req.wr && bus_req.addr == OFS_IRQ_MASK) begin
            mask_q <= bus_req.wdata[IRQ_HALT_BIT];
        end
    end
    // Ages saturate so a quiet spell never wraps back to a small value
    always_ff @(posedge clk or posedge rst) begin
        if (rst) cause_q <= 9'h1ff;
        else if (cmd_w || probe_trig) cause_q <= 9'h000;
        else if (cause_q != 9'h1ff) cause_q <= cause_q + 9'h001;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) cmd_age_q <= 9'h1ff;
        else if (cmd_w) cmd_age_q <= 9'h000;
        else if (cmd_age_q != 9'h1ff) cmd_age_q <= cmd_age_q + 9'h001;
    end
    a_sel_halt_now: assert property (@(posedge clk) disable iff (rst)
        halt_w && mine |-> ##2 halted_q) else $error("selected unit did not halt");
    a_all_halt_seq: assert property (@(posedge clk) disable iff (rst)
        halt_w && all_q |-> ##[1:SEQ_D] halted_q) else $error("all-mode halt late");
    a_reset_idle: assert property (@(posedge clk) disable iff (rst)
        rst_w && mine |=> !halted_q) else $error("reset command left unit halted");
    a_run_clocks: assert property (@(negedge clk) disable iff (rst)
        !halted_q [*3] |-> gclk) else $error("running domain lost a clock pulse");
    a_no_short: assert property (@(posedge clk) disable iff (rst)
        !gclk) else $error("gated clock high while source clock low");
    a_halt_cause: assert property (@(posedge clk) disable iff (rst)
        $rose(halted_q) |-> cause_q <= 9'd270) else $error("halt without trigger or command");
    a_halt_leave: assert property (@(posedge clk) disable iff (rst)
        $fell(halted_q) |-> cmd_age_q <= 9'd64) else $error("halt left without command");
    a_irq_on_halt: assert property (@(posedge clk) disable iff (rst)
        $rose(halted_q) && mask_q |-> ##[0:2] irq_q) else $error("halt entry raised no irq");
endmodule // cbu_unit_monitor

bind cbu_unit cbu_unit_monitor #(.DOMAIN_ID(DOMAIN_ID)) cbu_unit_monitor_inst (
    .clk(clk), .rst(rst), .bus_req(bus_req), .rdata_q(rdata_q),
    .probe_trig(probe_trig), .gclk(gclk), .halted_q(halted_q), .irq_q(irq_q));

// [clock_domain_hw_breakpoint_tb.sv]
// Self-checking bench for two clock breakpoint units on one host
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin mismatches++; \
    $display("BAD t=%0t got=%0h exp=%0h", $time, a, b); end end
module clock_domain_hw_breakpoint_tb
    import cbu_pkg::*;
;
    logic              clk, rst, probe0, probe2, sel2;
    cbu_bus_req_t      bus_req;
    logic [DATA_W-1:0] rdata0, rdata2, d;
    logic              gclk0, gclk2, halted0, halted2, irq0, irq2;
    int                n0, n2, mismatches, tests_run, cycles;

    cbu_unit #(.DOMAIN_ID(4'h0)) cbu_unit_inst (.clk(clk), .rst(rst), .bus_req(bus_req),
        .rdata_q(rdata0), .probe_trig(probe0), .gclk(gclk0), .halted_q(halted0), .irq_q(irq0));
    cbu_unit #(.DOMAIN_ID(4'h2)) cbu_unit_inst_d2 (.clk(clk), .rst(rst), .bus_req(bus_req),
        .rdata_q(rdata2), .probe_trig(probe2), .gclk(gclk2), .halted_q(halted2), .irq_q(irq2));
    cbu_host cbu_host_inst (.clk(clk), .rst(rst), .bus_req(bus_req),
        .rdata(sel2 ? rdata2 : rdata0));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Pulse counters are read at falling edges, clear of the gated edges
    always @(posedge gclk0) n0++;
    always @(posedge gclk2) n2++;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        if (mismatches == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic cmd(input int b);
        cbu_host_inst.wr(OFS_CMD, 32'h1 << b);
    endtask
    task automatic ctrl(input logic all, input logic [SEL_W-1:0] s);
        cbu_host_inst.wr(OFS_CTRL, {24'h0, s, 3'h0, all});
    endtask
    task automatic rd(input logic u2, input logic [ADDR_W-1:0] a);
        sel2 = u2;
        cbu_host_inst.rd(a, d);
    endtask
    task automatic pulse();
        @(posedge clk);
        probe0 <= 1'b1;
        @(posedge clk);
        probe0 <= 1'b0;
    endtask
    task automatic t_regs();
        rd(0, OFS_DELAY);
        `CHK(d, {24'h0, DELAY_RST})
        rd(1, OFS_STATUS);
        `CHK(d[1:0], 2'h0)
        rd(0, OFS_IRQ_MASK);
        `CHK(d, {30'h0, IRQ_MASK_RST})
        rd(0, 8'h40);
        `CHK(d, 32'h0)
    endtask
    task automatic t_single();
        int a, b;
        ctrl(1'b0, 4'h0);
        cmd(CMD_HALT_BIT);
        cyc(3);
        `CHK({halted0, halted2}, 2'b10)
        a = n0;
        b = n2;
        cyc(10);
        `CHK(n0, a)
        `CHK(n2, b + 10)
        cmd(CMD_STEP_BIT);
        cyc(6);
        `CHK(n0, a + 1)
        `CHK(halted0, 1'b1)
        cmd(CMD_PLAY_BIT);
        cyc(3);
        a = n0;
        cyc(10);
        `CHK(n0, a + 10)
    endtask
    task automatic t_trig();
        int i, i0;
        logic [DELAY_W-1:0] dl [3] = '{8'h00, 8'h03, 8'hff};
        cbu_host_inst.wr(OFS_IRQ_MASK, 32'h3);
        foreach (dl[k]) begin
            cbu_host_inst.arm(dl[k]);
            cbu_host_inst.wr(OFS_DELAY, 32'h9);
            cmd(CMD_STEP_BIT);
            rd(0, OFS_DELAY);
            `CHK(d[7:0], dl[k])
            rd(0, OFS_STATUS);
            `CHK(d[STAT_ARMED_BIT], 1'b1)
            pulse();
            i = 0;
            while (halted0 !== 1'b1 && i < 300) begin
                cyc(1);
                i++;
            end
            if (k == 0) i0 = i;
            `CHK(i, i0 + int'(dl[k]))
            cyc(3);
            `CHK(irq0, 1'b1)
            cmd(CMD_RESET_BIT);
            cbu_host_inst.wr(OFS_IRQ_STAT, 32'h3);
            cyc(3);
            `CHK({halted0, irq0}, 2'b00)
        end
        `CHK(i0 <= 2, 1'b1)
        cbu_host_inst.wr(OFS_IRQ_MASK, 32'h0);
    endtask
    // Lower domain must reach the level first, one gap per id apart
    task automatic seq(input logic lvl);
        int t0, t2;
        t0 = -1;
        t2 = -1;
        for (int i = 0; i < 30; i++) begin
            if (t0 < 0 && halted0 === lvl) t0 = i;
            if (t2 < 0 && halted2 === lvl) t2 = i;
            cyc(1);
        end
        `CHK(t2 - t0, 2 * int'(SEQ_GAP))
    endtask
    task automatic t_all();
        int a, b;
        ctrl(1'b1, 4'h0);
        cmd(CMD_HALT_BIT);
        seq(1'b1);
        a = n0;
        b = n2;
        cmd(CMD_STEP_BIT);
        cyc(20);
        `CHK({n0 - a, n2 - b}, {32'sd1, 32'sd1})
        cmd(CMD_PLAY_BIT);
        seq(1'b0);
    endtask
    task automatic t_sel();
        ctrl(1'b0, 4'h0);
        cbu_host_inst.arm(8'h02);
        ctrl(1'b0, 4'h2);
        rd(0, OFS_DELAY);
        `CHK(d, 32'h0)
        rd(0, OFS_STATUS);
        `CHK(d[STAT_ARMED_BIT], 1'b0)
        ctrl(1'b0, 4'h0);
        cbu_host_inst.arm(8'h00);
        cmd(CMD_RESET_BIT);
        pulse();
        cyc(5);
        `CHK(halted0, 1'b0)
        // Long delay under way; a forced halt must not wait for it
        cbu_host_inst.arm(8'hff);
        pulse();
        cmd(CMD_HALT_BIT);
        cyc(3);
        `CHK(halted0, 1'b1)
        rd(0, OFS_STATUS);
        `CHK(d[STAT_ARMED_BIT], 1'b0)
        cmd(CMD_RESET_BIT);
        cyc(3);
        `CHK(halted0, 1'b0)
    endtask

    initial begin
        rst = 1'b1;
        probe0 = 1'b0;
        probe2 = 1'b0;
        sel2 = 1'b0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_single();
        t_trig();
        t_all();
        t_sel();
        wrap_up();
    end
endmodule // clock_domain_hw_breakpoint_tb
